// ### sbit_params.svh
// Purpose: address map, field positions and reset values of the interval timer
// Assumes: 12-bit APB byte address, 32-bit data
// Notes:   definitions only
`ifndef SBIT_PARAMS_SVH
`define SBIT_PARAMS_SVH

`define SBIT_OFF_START   12'h000
`define SBIT_OFF_STOP    12'h004
`define SBIT_OFF_STAT    12'h008
`define SBIT_OFF_ISTAT   12'h00C
`define SBIT_OFF_IMASK   12'h010
`define SBIT_OFF_FILT    12'h014
`define SBIT_CH_PAGE     4'h1
`define SBIT_CH_MODE     2'h0
`define SBIT_CH_CMP      2'h1
`define SBIT_CH_CNT      2'h2

`define SBIT_HI_LSB      8
`define SBIT_MODE_LSB    0
`define SBIT_MODE_MSB    4

`define SBIT_CNT_RST     16'h0000
`define SBIT_CMP_RST     16'hFFFF
`define SBIT_CMP_MIN     16'h0001
`define SBIT_BYTE_RST    8'h00
`define SBIT_BYTE_ONE    8'h01
`define SBIT_WORD_ONE    16'h0001
`define SBIT_DATA_RST    32'h0000_0000

`define SBIT_SEL_DIV1    2'h0
`define SBIT_SEL_DIV2    2'h1
`define SBIT_SEL_DIV4    2'h2

`endif

// ### sbit_pkg.sv
// Purpose: shared types of the interval timer
// Assumes: nothing beyond the params header
// Notes:   mode layout is packed from bit 4 down to bit 0
package sbit_pkg;

    // per-channel mode word
    typedef struct packed {
        logic       split;
        logic       ext;
        logic [1:0] clk_sel;
        logic       one_shot;
    } sbit_mode_s;

endpackage

// ### sbit_timer.sv
// Purpose: six-channel 16-bit interval timer with APB registers and interrupt
// Assumes: pclk 20 MHz; ext_count_input asynchronous to pclk
// Notes:   timer clock is pclk divided by 1/2/4/8 or the external edge
//
// Behaviour
// - run status reads 0 when halted (reset), 1 while counting
// - in split mode status bits 13..8 show upper half run state
// - status bits 5..0 show channel, or lower half in split mode
// - start: status set at first timer tick, counting from second
// - on match, next tick raises interrupt and clears counter
// - repeat mode keeps counting after match; one-shot halts
// - stop: counter stops at first timer tick, status drops to 0
// - restart resumes from held count, not from zero
// - any write to the counter register clears it
// - interrupt period is compare value plus one; range 0x0001..0xFFFF
// - first period may be one tick off; later periods exact
// - a match coinciding with stop still raises the interrupt
// - external source: sampled input, count on each rising edge
// - external input passes a sampling stage that can be bypassed
// - writing 0 to start or stop bits changes nothing
// - upper-half status bits read zero in full 16-bit mode
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "sbit_params.svh"

module sbit_timer #(
    parameter int NCH = 6
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [5:0]  ext_count_input,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic      [5:0]  chan_match_irq
);

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    logic       setup_ph;
    logic       wr_acc;
    logic       hit_start;
    logic       hit_stop;
    logic       hit_stat;
    logic       hit_istat;
    logic       hit_imask;
    logic       hit_filt;
    logic       hit_ch;
    logic [2:0] ch_idx;
    logic [1:0] ch_sub;
    logic       mapped;
    logic       wr_start;
    logic       wr_stop;
    logic       wr_istat;
    logic       wr_imask;
    logic       wr_filt;

    assign setup_ph  = psel & ~penable;
    assign wr_acc    = psel & penable & pready & pwrite;
    assign hit_start = (paddr == `SBIT_OFF_START);
    assign hit_stop  = (paddr == `SBIT_OFF_STOP);
    assign hit_stat  = (paddr == `SBIT_OFF_STAT);
    assign hit_istat = (paddr == `SBIT_OFF_ISTAT);
    assign hit_imask = (paddr == `SBIT_OFF_IMASK);
    assign hit_filt  = (paddr == `SBIT_OFF_FILT);
    assign ch_idx    = paddr[6:4];
    assign ch_sub    = paddr[3:2];
    assign hit_ch    = (paddr[11:8] == `SBIT_CH_PAGE) & ~paddr[7]
                     & (paddr[1:0] == 2'b00) & (ch_sub != 2'b11)
                     & (32'(ch_idx) < NCH);
    assign mapped    = hit_start | hit_stop | hit_stat | hit_istat
                     | hit_imask | hit_filt | hit_ch;
    assign wr_start  = wr_acc & hit_start;
    assign wr_stop   = wr_acc & hit_stop;
    assign wr_istat  = wr_acc & hit_istat;
    assign wr_imask  = wr_acc & hit_imask;
    assign wr_filt   = wr_acc & hit_filt;

    ////////////////////////////////////////////////////////////////////////
    // state

    sbit_pkg::sbit_mode_s mode [NCH];
    logic [15:0]          cmp  [NCH];
    logic [15:0]          cnt  [NCH];
    logic [15:0]          next_cnt [NCH];
    logic [NCH-1:0]       run_lo;
    logic [NCH-1:0]       run_hi;
    logic [NCH-1:0]       start_lo;
    logic [NCH-1:0]       start_hi;
    logic [NCH-1:0]       stop_lo;
    logic [NCH-1:0]       stop_hi;
    logic [NCH-1:0]       lo_evt;
    logic [NCH-1:0]       hi_evt;
    logic [NCH-1:0]       tick;
    logic [13:0]          irq_stat;
    logic [13:0]          irq_mask;
    logic [13:0]          evt_vec;
    logic [13:0]          run_vec;
    logic [NCH-1:0]       filt_en;
    logic [2:0]           presc;
    logic [NCH-1:0]       ext_s1;
    logic [NCH-1:0]       ext_s2;
    logic [NCH-1:0]       ext_s3;
    logic [NCH-1:0]       ext_lvl;
    logic [NCH-1:0]       ext_prev;
    logic [NCH-1:0]       ext_rise;
    logic [NCH-1:0]       next_ext_lvl;

    ////////////////////////////////////////////////////////////////////////
    // timer clock sources

    // free-running prescaler keeps every later period exact
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc <= 3'h0;
        end else begin
            presc <= presc + 3'h1;
        end
    end

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1 <= '0;
            ext_s2 <= '0;
        end else begin
            ext_s1 <= ext_count_input[NCH-1:0];
            ext_s2 <= ext_s1;
        end
    end

    // optional sampling filter
    // with the filter on, a level must be seen twice before it is taken,
    // so pulses shorter than two pclk cycles can be lost
    assign next_ext_lvl = (filt_en & ext_s2 & ext_s3)
                        | (filt_en & (ext_s2 ^ ext_s3) & ext_lvl)
                        | (~filt_en & ext_s2);

    // rising edge of the sampled input
    assign ext_rise = ext_lvl & ~ext_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s3   <= '0;
            ext_lvl  <= '0;
            ext_prev <= '0;
        end else begin
            ext_s3   <= ext_s2;
            ext_lvl  <= next_ext_lvl;
            ext_prev <= ext_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channels

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic       sel_ch;
        logic       div_tick;
        logic       split;
        logic       lo_match;
        logic       hi_match;
        logic       lo_inc;
        logic       hi_inc;
        logic [7:0] lo_next;
        logic [7:0] hi_next;
        logic [15:0] full_next;
        logic       cnt_clr;
        logic       next_run_lo;
        logic       next_run_hi;
        logic [15:0] cmp_wdata;

        assign sel_ch   = hit_ch & (ch_idx == 3'(i));
        assign split    = mode[i].split;
        assign div_tick = (mode[i].clk_sel == `SBIT_SEL_DIV1) ? 1'b1
                        : (mode[i].clk_sel == `SBIT_SEL_DIV2) ? presc[0]
                        : (mode[i].clk_sel == `SBIT_SEL_DIV4) ? &presc[1:0]
                        : &presc;
        assign tick[i]  = mode[i].ext ? ext_rise[i] : div_tick;

        // match compare per half or full word
        assign lo_match  = split ? (cnt[i][7:0] == cmp[i][7:0])
                                 : (cnt[i] == cmp[i]);
        assign hi_match  = (cnt[i][15:8] == cmp[i][15:8]);
        // match is honoured even on the stopping tick
        assign lo_evt[i] = tick[i] & run_lo[i] & lo_match;
        assign hi_evt[i] = tick[i] & run_hi[i] & split & hi_match;

        // count only on ticks after the run flag is already set
        assign lo_inc = tick[i] & run_lo[i] & ~stop_lo[i] & ~lo_evt[i];
        assign hi_inc = tick[i] & run_hi[i] & ~stop_hi[i] & ~hi_evt[i];

        // clear on match, hold value while halted
        assign lo_next   = lo_evt[i] ? `SBIT_BYTE_RST
                         : lo_inc ? cnt[i][7:0] + `SBIT_BYTE_ONE
                         : cnt[i][7:0];
        assign hi_next   = hi_evt[i] ? `SBIT_BYTE_RST
                         : hi_inc ? cnt[i][15:8] + `SBIT_BYTE_ONE
                         : cnt[i][15:8];
        assign full_next = lo_evt[i] ? `SBIT_CNT_RST
                         : lo_inc ? cnt[i] + `SBIT_WORD_ONE
                         : cnt[i];

        assign cnt_clr     = wr_acc & sel_ch & (ch_sub == `SBIT_CH_CNT);
        assign next_cnt[i] = cnt_clr ? `SBIT_CNT_RST
                           : split ? {hi_next, lo_next} : full_next;

        // stop wins on the tick; one-shot halts at match
        assign next_run_lo = ~tick[i] ? run_lo[i]
                           : stop_lo[i] ? 1'b0
                           : (lo_evt[i] & mode[i].one_shot) ? 1'b0
                           : start_lo[i] ? 1'b1
                           : run_lo[i];
        // upper half never runs in full 16-bit mode
        assign next_run_hi = ~split ? 1'b0
                           : ~tick[i] ? run_hi[i]
                           : stop_hi[i] ? 1'b0
                           : (hi_evt[i] & mode[i].one_shot) ? 1'b0
                           : start_hi[i] ? 1'b1
                           : run_hi[i];

        // zero is not a legal compare value
        assign cmp_wdata = (pwdata[15:0] == `SBIT_CNT_RST) ? `SBIT_CMP_MIN
                                                           : pwdata[15:0];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt[i]    <= `SBIT_CNT_RST;
                run_lo[i] <= 1'b0;
                run_hi[i] <= 1'b0;
            end else begin
                cnt[i]    <= next_cnt[i];
                run_lo[i] <= next_run_lo;
                run_hi[i] <= next_run_hi;
            end
        end

        // only written ones post a request; a new write beats the
        // consuming tick so a request is never dropped
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                start_lo[i] <= 1'b0;
                start_hi[i] <= 1'b0;
                stop_lo[i]  <= 1'b0;
                stop_hi[i]  <= 1'b0;
            end else begin
                start_lo[i] <= (wr_start & pwdata[i])
                             | (start_lo[i] & ~tick[i]);
                start_hi[i] <= (wr_start & pwdata[`SBIT_HI_LSB + i] & split)
                             | (start_hi[i] & ~tick[i]);
                stop_lo[i]  <= (wr_stop & pwdata[i])
                             | (stop_lo[i] & ~tick[i]);
                stop_hi[i]  <= (wr_stop & pwdata[`SBIT_HI_LSB + i] & split)
                             | (stop_hi[i] & ~tick[i]);
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mode[i] <= '0;
                cmp[i]  <= `SBIT_CMP_RST;
            end else begin
                if (wr_acc & sel_ch & (ch_sub == `SBIT_CH_MODE)) begin
                    mode[i] <= sbit_pkg::sbit_mode_s'(
                        pwdata[`SBIT_MODE_MSB:`SBIT_MODE_LSB]);
                end
                if (wr_acc & sel_ch & (ch_sub == `SBIT_CH_CMP)) begin
                    cmp[i] <= cmp_wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status and interrupts

    assign run_vec = {run_hi, 2'b00, run_lo};
    assign evt_vec = {hi_evt, 2'b00, lo_evt};

    // set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~(wr_istat ? pwdata[13:0] : 14'h0000))
                      | evt_vec;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
            filt_en  <= '0;
        end else begin
            if (wr_imask) begin
                irq_mask <= pwdata[13:0];
            end
            if (wr_filt) begin
                filt_en <= pwdata[NCH-1:0];
            end
        end
    end

    // match pulse on the tick that clears the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_match_irq <= '0;
            irq            <= 1'b0;
        end else begin
            chan_match_irq <= 6'(lo_evt | hi_evt);
            irq            <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path; no wait state, data captured in the setup cycle

    logic [31:0] rd_data;
    logic [31:0] ch_rd;

    assign ch_rd = (ch_sub == `SBIT_CH_MODE)
                 ? {27'h0, mode[ch_idx]}
                 : (ch_sub == `SBIT_CH_CMP) ? {16'h0000, cmp[ch_idx]}
                 : {16'h0000, cnt[ch_idx]};

    // status is read only; no write path exists for it
    assign rd_data = hit_stat  ? {18'h0, run_vec}
                   : hit_istat ? {18'h0, irq_stat}
                   : hit_imask ? {18'h0, irq_mask}
                   : hit_filt  ? {26'h0, filt_en}
                   : hit_ch    ? ch_rd
                   : `SBIT_DATA_RST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `SBIT_DATA_RST;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~mapped;
            prdata  <= (setup_ph & ~pwrite) ? rd_data : `SBIT_DATA_RST;
        end
    end

endmodule

// ### sbit_timer_properties.sv
// Purpose: port-level checks of the interval timer
// Assumes: pclk only clock, presetn async active low
// Notes:   bound to every sbit_timer instance
`timescale 1ns/10ps
module sbit_timer_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [5:0]  ext_count_input,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic [5:0]  chan_match_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_cause_a: assert property (!(psel && !penable) |=> !pready)
        else $error("ready without setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    unmapped_err_a: assert property (psel && !penable && paddr == 12'h200
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped address accepted");
    // start and stop are write-only
    cmd_reads_zero_a: assert property (psel && !penable && !pwrite &&
        paddr[11:3] == 9'h000 |=> prdata == 32'h0000_0000)
        else $error("command register read nonzero");
    status_ok_a: assert property (psel && !penable && paddr == 12'h008
        |=> !pslverr)
        else $error("status access refused");
    cover property (chan_match_irq != 6'h00);
    cover property ($rose(irq));
    cover property (pslverr);
endmodule
bind sbit_timer sbit_timer_properties u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .ext_count_input(ext_count_input),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .chan_match_irq(chan_match_irq));

// ### sixteen_bit_interval_timer_test.sv
// Purpose: register-level test of the six-channel interval timer
// Assumes: timer clock select 0 ticks every pclk
// Notes:   waits are bounded; a hang ends in conclude
`timescale 1ns/10ps
module sixteen_bit_interval_timer_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, c1;
    logic [5:0]  ext, mirq;
    int          n_fail, compares, k;

    sbit_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .ext_count_input(ext), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .chan_match_irq(mirq));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    ////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // hold the request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            conclude();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, q);
    endtask
    // k = cycles until the next match pulse of channel ch
    task automatic gap(input int ch);
        k = 0;
        do begin
            @(posedge pclk);
            #1;
            k++;
        end while (mirq[ch] !== 1'b1 && k < 300);
        if (k == 300) begin
            n_fail++;
            conclude();
        end
    endtask
    // each level held longer than two pclk cycles
    task automatic pls(input int n);
        repeat (n) begin
            @(posedge pclk);
            ext[3] <= 1'b1;
            repeat (3) @(posedge pclk);
            ext[3] <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask
    // repeat period of channel ch for mode word m, compare value 4
    task automatic per(input int ch, input logic [31:0] m,
                       input logic [31:0] e);
        wr(12'h100 + 12'(ch * 16), m);
        wr(12'h104 + 12'(ch * 16), 32'h0000_0004);
        wr(12'h000, 32'h0000_0001 << ch);
        gap(ch);
        gap(ch);
        chk("divided period", e, 32'(k));
        wr(12'h004, 32'h0000_0001 << ch);
    endtask
    ////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ext} = '0;
        presetn = 1'b0;
        n_fail = 0;
        compares = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h008, 32'h0000_0000, "run status");
        rd(12'h104, 32'h0000_FFFF, "compare reset");
        rd(12'h108, 32'h0000_0000, "counter reset");
        wr(12'h008, 32'h0000_3F3F);
        wr(12'h000, 32'h0000_0000);
        rd(12'h008, 32'h0000_0000, "status after writes");
        rd(12'h200, 32'h0000_0000, "unmapped read");
        chk("unmapped error", 32'h0000_0001, 32'(err));
        rd(12'h004, 32'h0000_0000, "stop reads zero");
        wr(12'h104, 32'h0000_0004);
        wr(12'h010, 32'h0000_0001);
        wr(12'h000, 32'h0000_0101);
        rd(12'h008, 32'h0000_0001, "full status");
        gap(0);
        gap(0);
        chk("period", 32'h0000_0005, 32'(k));
        gap(0);
        chk("later period", 32'h0000_0005, 32'(k));
        chk("irq set", 32'h0000_0001, 32'(irq));
        wr(12'h004, 32'h0000_0001);
        rd(12'h008, 32'h0000_0000, "stopped");
        rd(12'h00C, 32'h0000_0001, "irq sticky");
        wr(12'h00C, 32'h0000_0001);
        rd(12'h00C, 32'h0000_0000, "irq cleared");
        chk("irq clear", 32'h0000_0000, 32'(irq));
        wr(12'h104, 32'h0000_FFFF);
        wr(12'h108, 32'h0000_0000);
        rd(12'h108, 32'h0000_0000, "counter clear");
        wr(12'h000, 32'h0000_0001);
        repeat (40) @(posedge pclk);
        wr(12'h004, 32'h0000_0001);
        apb(1'b0, 12'h108, 32'h0000_0000);
        c1 = q;
        wr(12'h000, 32'h0000_0001);
        repeat (10) @(posedge pclk);
        wr(12'h004, 32'h0000_0001);
        apb(1'b0, 12'h108, 32'h0000_0000);
        chk("resume", 32'h0000_0001, 32'(q > c1));
        wr(12'h108, 32'h0000_1234);
        rd(12'h108, 32'h0000_0000, "any write clears");
        wr(12'h110, 32'h0000_0001);
        wr(12'h114, 32'h0000_0003);
        wr(12'h000, 32'h0000_0002);
        gap(1);
        repeat (3) @(posedge pclk);
        rd(12'h008, 32'h0000_0000, "one-shot halt");
        rd(12'h118, 32'h0000_0000, "match clears count");
        rd(12'h00C, 32'h0000_0002, "one-shot irq status");
        chk("irq masked", 32'h0000_0000, 32'(irq));
        wr(12'h010, 32'h0000_0003);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq unmasked", 32'h0000_0001, 32'(irq));
        wr(12'h00C, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq dropped", 32'h0000_0000, 32'(irq));
        wr(12'h120, 32'h0000_0010);
        wr(12'h000, 32'h0000_0400);
        rd(12'h008, 32'h0000_0400, "upper half run");
        wr(12'h000, 32'h0000_0004);
        rd(12'h008, 32'h0000_0404, "both halves run");
        wr(12'h004, 32'h0000_0404);
        rd(12'h008, 32'h0000_0000, "halves stopped");
        wr(12'h130, 32'h0000_0008);
        wr(12'h000, 32'h0000_0008);
        pls(3);
        rd(12'h138, 32'h0000_0002, "first edges");
        pls(5);
        rd(12'h138, 32'h0000_0007, "edge count");
        wr(12'h014, 32'h0000_0008);
        pls(5);
        rd(12'h138, 32'h0000_000C, "filtered count");
        per(4, 32'h0000_0002, 32'h0000_000A);
        per(5, 32'h0000_0004, 32'h0000_0014);
        per(4, 32'h0000_0006, 32'h0000_0028);
        conclude();
    end
endmodule
